// File: hw/stt_timer.sv
`timescale 1ns/1ps
`include "stt_defines.svh"
module stt_timer #(
  // Counter and period widths
  parameter int CNT_W = `STT_CNT_W,
  parameter int PER_W = `STT_PER_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Software control
  input wire stt_pkg::stt_ctrl_t ctrl_i,
  // Interrupt controller handshake
  input wire logic handler_entry_i,
  // Status and interrupt
  output stt_pkg::stt_stat_t stat_o,
  output logic irq_o
);
  import stt_pkg::*;

  logic [CNT_W-1:0] count_q;
  logic [PER_W-1:0] period_q;
  logic pending_q;
  logic irq_q;
  logic wrap;
  logic per_new_q;

  // Reload value as counter width
  function automatic logic [`STT_CNT_W-1:0] reload_of(
    input logic [`STT_PER_W-1:0] per);
    logic [`STT_PER_W-1:0] m;
    m = per - `STT_PER_MIN;
    reload_of = m[`STT_CNT_W-1:0];
  endfunction : reload_of

  // Legal period: one tick up to full range
  function automatic logic period_ok(input logic [`STT_PER_W-1:0] per);
    period_ok = (per >= `STT_PER_MIN) && (per <= `STT_PER_MAX);
  endfunction : period_ok

  //////////////////////////////////////////////////////////////////////////
  // Refuse widths that do not match the carrier struct fields
  if (CNT_W != $bits(stat_o.count)) begin : g_cnt_w_bad
    $error("count width does not match status carrier");
  end
  if (PER_W != $bits(stat_o.period)) begin : g_per_w_bad
    $error("period width does not match status carrier");
  end
  // Period must reach one past the largest count
  if (PER_W <= CNT_W) begin : g_per_narrow
    $error("period width too narrow for full count range");
  end

  //////////////////////////////////////////////////////////////////////////
  // Period register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_q <= `STT_PER_RST;
    end else if (ctrl_i.period_wr && period_ok(ctrl_i.period)) begin
      period_q <= ctrl_i.period;
    end
  end

  // Wrap: enabled counter sitting at zero
  assign wrap = ctrl_i.count_en && (count_q == `STT_CNT_ZERO);

  //////////////////////////////////////////////////////////////////////////
  // Down counter
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= `STT_CNT_ZERO;
    end else if (ctrl_i.current_wr) begin
      count_q <= `STT_CNT_ZERO;
    end else if (wrap) begin
      count_q <= reload_of(period_q);
    end else if (ctrl_i.count_en) begin
      count_q <= count_q - `STT_CNT_ONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pending interrupt, set wins over clear
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending_q <= 1'b0;
    end else if (wrap && !ctrl_i.current_wr) begin
      pending_q <= 1'b1;
    end else if (handler_entry_i) begin
      pending_q <= 1'b0;
    end
  end

  // period changed flag
  // Count may exceed a new period until the next reload
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      per_new_q <= 1'b0;
    end else if (ctrl_i.period_wr) begin
      per_new_q <= 1'b1;
    end else if (wrap && !ctrl_i.current_wr) begin
      per_new_q <= 1'b0;
    end
  end

  // Masked request to processor
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ctrl_i.irq_en && pending_q && !handler_entry_i;
    end
  end

  assign irq_o = irq_q;
  assign stat_o.count = count_q;
  assign stat_o.period = period_q;
  assign stat_o.irq_pending = pending_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence cur_write_s;
    ctrl_i.current_wr;
  endsequence

  reload_seq_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    cur_write_s ##1 (ctrl_i.count_en && !ctrl_i.current_wr) |=>
      count_q == reload_of($past(period_q)))
    else $error("no reload after count write");

  write_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ctrl_i.current_wr |=> count_q == `STT_CNT_ZERO)
    else $error("count write did not clear");

  hold_off_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !ctrl_i.count_en && !ctrl_i.current_wr |=> $stable(count_q))
    else $error("count moved while disabled");

  dec_step_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ctrl_i.count_en && !ctrl_i.current_wr && count_q != `STT_CNT_ZERO
    |=> count_q == $past(count_q) - `STT_CNT_ONE)
    else $error("counter did not decrement");

  wrap_set_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    wrap && !ctrl_i.current_wr |=> pending_q)
    else $error("wrap did not set pending");

  no_irq_off_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !ctrl_i.count_en && !pending_q |=> !pending_q)
    else $error("pending set while disabled");

  entry_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    handler_entry_i && !wrap |=> !pending_q && !irq_q)
    else $error("handler entry did not clear");

  mask_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !ctrl_i.irq_en |=> !irq_o)
    else $error("masked interrupt reached core");

  pass_through_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ctrl_i.irq_en && pending_q && !handler_entry_i |=> irq_o)
    else $error("enabled interrupt not passed");

  range_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !per_new_q |-> {1'b0, count_q} < period_q)
    else $error("count outside period range");

  // Enable after a hold resumes from the held count
  sequence resume_s;
    !ctrl_i.count_en ##1
      (ctrl_i.count_en && !ctrl_i.current_wr && count_q != `STT_CNT_ZERO);
  endsequence

  resume_held_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    resume_s |=> count_q == $past(count_q) - `STT_CNT_ONE)
    else $error("enable did not resume from held count");

  reload_val_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    wrap && !ctrl_i.current_wr |=> count_q == reload_of($past(period_q)))
    else $error("wrap did not reload period");

  mask_keeps_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !ctrl_i.irq_en && wrap && !ctrl_i.current_wr |=> pending_q)
    else $error("masked wrap lost its source");

  write_no_pend_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ctrl_i.current_wr && !pending_q |=> !pending_q)
    else $error("count write raised pending");

  irq_source_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    irq_o |-> $past(pending_q) && $past(ctrl_i.irq_en))
    else $error("request without enabled pending source");

  period_keep_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ctrl_i.period_wr && !period_ok(ctrl_i.period) |=> $stable(period_q))
    else $error("illegal period was taken");

  period_load_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ctrl_i.period_wr && period_ok(ctrl_i.period) |=>
      period_q == $past(ctrl_i.period))
    else $error("legal period was not taken");

endmodule : stt_timer

// File: hw/stt_defines.svh
`ifndef STT_DEFINES_SVH
`define STT_DEFINES_SVH

// Counter geometry
`define STT_CNT_W 24
`define STT_PER_W 25
`define STT_CNT_ZERO 24'h000000
`define STT_CNT_ONE 24'h000001
`define STT_PER_MIN 25'h0000001
`define STT_PER_MAX 25'h1000000
`define STT_PER_RST 25'h1000000

`endif

// File: hw/stt_pkg.sv
`include "stt_defines.svh"

package stt_pkg;

  // Software control of the timer
  typedef struct packed {
    logic count_en;
    logic irq_en;
    logic period_wr;
    logic [`STT_PER_W-1:0] period;
    logic current_wr;
  } stt_ctrl_t;

  // Observable timer state
  typedef struct packed {
    logic [`STT_CNT_W-1:0] count;
    logic [`STT_PER_W-1:0] period;
    logic irq_pending;
  } stt_stat_t;

endpackage : stt_pkg

// File: dv/stt_nic_model.sv
`timescale 1ns/1ps
module stt_nic_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Request and latency
  input wire logic irq_i,
  input wire logic [1:0] lat_i,
  // Handler entry
  output logic entry_o
);
  logic [1:0] wait_q;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 2'h0;
      entry_o <= 1'b0;
    end else begin
      entry_o <= irq_i && !entry_o && wait_q == lat_i;
      wait_q <= (irq_i && wait_q != lat_i) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : stt_nic_model

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import stt_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  stt_ctrl_t ctrl = '0;
  stt_stat_t stat;
  logic irq, entry, irq_d = 1'b0;
  logic [1:0] lat = 2'h0;
  logic [23:0] exp_c = 24'h000000;
  logic [24:0] per = 25'h0000004;
  logic [23:0] exp_q[$];
  int mismatches = 0, num_checks = 0, rises = 0;
  event smp;
  always #2.5 core_clk_i = ~core_clk_i;
  stt_timer dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .ctrl_i(ctrl), .handler_entry_i(entry), .stat_o(stat), .irq_o(irq));
  stt_nic_model nic (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .irq_i(irq), .lat_i(lat), .entry_o(entry));
  task chk(input string n, input logic [24:0] e, input logic [24:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Count watcher takes the oldest note
  always @(smp) begin
    chk("count", {1'b0, exp_q.pop_front()}, {1'b0, stat.count});
  end
  ////////////////////////////////////////////////////////////////////
  task step(input logic en, input logic cw);
    ctrl.count_en = en;
    ctrl.current_wr = cw;
    @(negedge core_clk_i);
    if (irq === 1'b1 && irq_d !== 1'b1) rises++;
    irq_d = irq;
    if (cw) exp_c = 24'h000000;
    else if (en && exp_c == 24'h000000) exp_c = 24'(per - 25'h0000001);
    else if (en) exp_c = exp_c - 24'h000001;
    exp_q.push_back(exp_c);
    ->smp;
  endtask : step
  task wr_per(input logic [24:0] v);
    ctrl.period = v;
    ctrl.period_wr = 1'b1;
    @(negedge core_clk_i);
    ctrl.period_wr = 1'b0;
  endtask : wr_per
  task irq_run(input logic ie, input int want);
    ctrl.irq_en = ie;
    repeat (2 * per) step(1'b1, 1'b0);
    rises = 0;
    repeat (3 * per) step(1'b1, 1'b0);
    chk("irq rises", 25'(want), 25'(rises));
    $display("irq test done");
  endtask : irq_run
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    void'($urandom(62134));
    lat = 2'($urandom % 3);
    repeat (12) @(negedge core_clk_i);
    resetn_i = 1'b1;
    chk("period", 25'h1000000, stat.period);
    wr_per(25'h0000000);
    chk("period", 25'h1000000, stat.period);
    per = 25'($urandom % 8 + 5);
    wr_per(per);
    chk("period", per, stat.period);
    $display("period test done");
    step(1'b0, 1'b1);
    repeat (80) step($urandom % 4 != 0, $urandom % 12 == 0);
    $display("count test done");
    irq_run(1'b1, 3);
    irq_run(1'b0, 0);
    chk("pending", 25'h1, {24'h0, stat.irq_pending});
    end_sim;
  end
endmodule : testbench
